/* host_bus_model.sv */
// Host processor model on the stacked 8/16-bit I/O bus.
// Assumes the board answers on board_sel while a strobe is held.
`timescale 1ns/10ps

module host_bus_model
	import io_window_pkg::*;
(
	input wire logic clk_sys,
	input wire logic board_sel,
	input wire logic [4:0] board_offset,
	output host_req_type req
);
	// Idle bus: strobes high, data shows the inverse of its last value
	initial
	begin
		req = '{addr: 16'h0000, wdata: 8'hFF, iow: 1'b1, ior: 1'b1, dma: 1'b0};
	end

	// One byte cycle; the strobe is held 5 edges, longer than the sync path
	task automatic bus_cycle(input logic [15:0] a, input logic [7:0] d,
		input logic wr, input logic dm, output logic sel,
		output logic [4:0] ofs);
		@(posedge clk_sys);
		#1;
		req.addr = a;
		req.wdata = d;
		req.dma = dm;
		req.iow = !wr;
		req.ior = wr;
		repeat (4) @(posedge clk_sys);
		#1;
		sel = board_sel;
		ofs = board_offset;
		@(posedge clk_sys);
		#1;
		// Released data is not left showing the written byte
		req.iow = 1'b1;
		req.ior = 1'b1;
		req.dma = 1'b0;
		req.wdata = ~d;
		repeat (3) @(posedge clk_sys);
		// Return just past an edge so callers never change pins on it
		#1;
	endtask
endmodule // host_bus_model

/* io_window_address_decode.sv */
// Host-bus front end of a buffered digital I/O board: window decode,
// interrupt level routing, buffer enable/direction and change-of-state enable.
// Assumes host bus signals and straps are asynchronous pins; one clock.
`timescale 1ns/10ps

module io_window_address_decode
	import io_window_pkg::*;
#(
	parameter int SYNC_STAGES = 2
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [15:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_iow_n,
	input wire logic host_ior_n,
	input wire logic host_dma,
	input wire logic [4:0] base_strap_fit,
	input wire logic [15:0] irq_strap_fit,
	input wire logic board_irq,
	output logic board_sel,
	output logic [4:0] board_offset,
	output logic [15:0] host_irq,
	output logic [3:0] grp0_dir_in,
	output logic [3:0] grp1_dir_in,
	output logic [1:0] buf_enable,
	output logic [5:0] cos_enable
);

	// Two-stage synchronisers for every pin input
	host_req_type req_s1_q, req_s2_q;
	logic [4:0] base_s1_q, base_s2_q;
	logic [15:0] lvl_s1_q, lvl_s2_q;
	logic irq_s1_q, irq_s2_q;
	logic iow_prev_q;          // Edge detect on synchronised write strobe

	host_req_type req_raw;
	always_comb
	begin
		req_raw.addr = host_addr;
		req_raw.wdata = host_wdata;
		req_raw.iow = !host_iow_n;
		req_raw.ior = !host_ior_n;
		req_raw.dma = host_dma;
	end

	// Synchroniser flops: first stage read only by the second
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_s1_q <= '0;
			req_s2_q <= '0;
			base_s1_q <= '0;
			base_s2_q <= '0;
			lvl_s1_q <= '0;
			lvl_s2_q <= '0;
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			iow_prev_q <= 1'b0;
		end
		else
		begin
			req_s1_q <= req_raw;
			req_s2_q <= req_s1_q;
			base_s1_q <= base_strap_fit;
			base_s2_q <= base_s1_q;
			lvl_s1_q <= irq_strap_fit;
			lvl_s2_q <= lvl_s1_q;
			irq_s1_q <= board_irq;
			irq_s2_q <= irq_s1_q;
			iow_prev_q <= req_s2_q.iow;
		end
	end

	// Straps in negative-true sense: fitted jumper means a zero bit
	logic [4:0] base_bits;
	assign base_bits = ~base_s2_q;

	logic hit;
	logic [4:0] offset;
	io_window_match u_match (
		.addr(req_s2_q.addr),
		.dma(req_s2_q.dma),
		.base_bits(base_bits),
		.hit(hit),
		.offset(offset)
	);

	// With A9 and A8 both fitted the window would sit below 100h, on top
	// of the host's own system devices, so such a base is never claimed.
	logic base_legal;
	assign base_legal = base_bits[BASE_MSB-BASE_LSB -: 2] != 2'b00;

	// Registered state: buffer control per group, COS enables, select
	logic sel_q, sel_d;
	logic [4:0] ofs_q, ofs_d;
	buf_ctl_type [GROUPS-1:0] buf_q, buf_d;
	logic [1:0] tri_en_q, tri_en_d;        // Software buffer-control option
	logic [5:0] cos_q, cos_d;
	logic [15:0] irq_q, irq_d;
	logic wr_pulse;

	assign wr_pulse = req_s2_q.iow && !iow_prev_q;

	// Next-state for select, configuration and interrupt routing
	always_comb
	begin
		sel_d = hit && base_legal && (req_s2_q.iow || req_s2_q.ior);
		ofs_d = offset;
		buf_d = buf_q;
		tri_en_d = tri_en_q;
		cos_d = cos_q;
		if (wr_pulse && hit && base_legal)
		begin
			for (int g = 0; g < GROUPS; g++)
			begin
				// Control byte with set flag: direction follows it
				if (offset == (g == 0 ? OFS_CTRL0 : OFS_CTRL1)
					&& req_s2_q.wdata[CTL_SET])
				begin
					buf_d[g].dir_in = {req_s2_q.wdata[CTL_A],
						req_s2_q.wdata[CTL_B], req_s2_q.wdata[CTL_CHI],
						req_s2_q.wdata[CTL_CLO]};
					// Set flag tristates when the option is on
					if (tri_en_q[g])
						buf_d[g].enable = 1'b0;
				end
				// Buffer write: bit 7 low opens, high tristates
				if (offset == (g == 0 ? OFS_BUF0 : OFS_BUF1) && tri_en_q[g])
					buf_d[g].enable = !req_s2_q.wdata[CTL_SET];
				// Clearing the option hands the group back to always-on
				if (offset == OFS_TRI && !req_s2_q.wdata[g])
					buf_d[g].enable = 1'b1;
			end
			if (offset == OFS_TRI)
				tri_en_d = req_s2_q.wdata[GROUPS-1:0];
			if (offset == OFS_COS_EN)
				cos_d = req_s2_q.wdata[GROUPS*PORTS-1:0];
		end
		// Drive only the first fitted legal level; one level at most
		irq_d = '0;
		for (int i = IRQ_LINES - 1; i >= 0; i--)
		begin
			if (lvl_s2_q[i] && IRQ_LEGAL[i])
			begin
				irq_d = '0;
				irq_d[i] = irq_s2_q;
			end
		end
	end

	// Register stage; buffers start as inputs and enabled
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_q <= 1'b0;
			ofs_q <= '0;
			for (int g = 0; g < GROUPS; g++)
			begin
				buf_q[g].dir_in <= DIR_IN;
				buf_q[g].enable <= 1'b1;
			end
			tri_en_q <= '0;
			cos_q <= '0;
			irq_q <= '0;
		end
		else
		begin
			sel_q <= sel_d;
			ofs_q <= ofs_d;
			buf_q <= buf_d;
			tri_en_q <= tri_en_d;
			cos_q <= cos_d;
			irq_q <= irq_d;
		end
	end

	assign board_sel = sel_q;
	assign board_offset = ofs_q;
	assign host_irq = irq_q;
	assign grp0_dir_in = buf_q[0].dir_in;
	assign grp1_dir_in = buf_q[1].dir_in;
	assign buf_enable = {buf_q[1].enable, buf_q[0].enable};
	assign cos_enable = cos_q;

	// Select follows a matching strobe one cycle later
	a_sel_match: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		board_sel |-> $past(hit && base_legal))
		else $error("select without address match");

	a_no_dma_sel: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		$past(req_s2_q.dma) |-> !board_sel)
		else $error("select during DMA cycle");

	a_window_range: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		board_sel |-> $past(req_s2_q.addr) >= 16'h0100
		&& $past(req_s2_q.addr) <= 16'h03FF)
		else $error("select outside 100h..3FFh");

	a_offset_low: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		board_sel |-> board_offset == $past(req_s2_q.addr[4:0]))
		else $error("offset not low address bits");

	a_strap_invert: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		board_sel |-> $past(req_s2_q.addr[9:5]) == ~$past(base_s2_q))
		else $error("base not inverted strap");

	a_irq_onehot: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		$onehot0(host_irq) && ((host_irq & ~IRQ_LEGAL) == '0))
		else $error("irq on illegal or several levels");

	sequence s_cos_write;
		wr_pulse && hit && base_legal && offset == OFS_COS_EN;
	endsequence
	a_cos_write: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		s_cos_write |=> cos_enable == $past(req_s2_q.wdata[5:0]))
		else $error("change-of-state enable not stored");

	sequence s_ctl_write0;
		wr_pulse && hit && base_legal && offset == OFS_CTRL0
			&& req_s2_q.wdata[CTL_SET];
	endsequence
	a_dir_follow: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		s_ctl_write0 |=> grp0_dir_in[3] == $past(req_s2_q.wdata[CTL_A])
		&& grp0_dir_in[0] == $past(req_s2_q.wdata[CTL_CLO]))
		else $error("buffer direction not following control");

endmodule // io_window_address_decode

/* io_window_match.sv */
// Window comparator: decides whether a host address falls in the board's
// 32-byte block. Assumes inputs are already synchronised to clk_sys.
`timescale 1ns/10ps

module io_window_match
	import io_window_pkg::*;
(
	input wire logic [15:0] addr,
	input wire logic dma,
	input wire logic [4:0] base_bits,
	output logic hit,
	output logic [4:0] offset
);

	// Bits 9..5 must equal the strapped base, upper bits zero, no DMA
	always_comb
	begin
		hit = (addr[BASE_MSB:BASE_LSB] == base_bits)
			&& (addr[HIGH_MSB:HIGH_LSB] == HIGH_ZERO)
			&& !dma;
		offset = addr[OFS_W-1:0];
	end

endmodule // io_window_match

/* io_window_pkg.sv */
// Package for the host I/O window decoder: address layout, strap widths,
// interrupt levels, board register offsets and carrier structs.
// Assumes a single 100 MHz system clock and synchronous sampled host strobes.
package io_window_pkg;

	// Host I/O address layout
	localparam int ADDR_W = 16;
	localparam int OFS_W = 5;          // Offset inside the 32-byte window
	localparam int STRAP_W = 5;        // Straps cover address bits 9..5
	localparam int BASE_LSB = 5;
	localparam int BASE_MSB = 9;
	localparam int HIGH_LSB = 10;
	localparam int HIGH_MSB = 15;
	localparam logic [5:0] HIGH_ZERO = 6'h00;
	localparam int WINDOW_BYTES = 32;

	// Interrupt level routing: one-hot over host levels 0..15
	localparam int IRQ_LINES = 16;
	localparam logic [15:0] IRQ_LEGAL = 16'hDEF8;  // 3-7, 9-12, 14, 15

	// Board register offsets handled here
	localparam logic [4:0] OFS_CTRL0 = 5'h03;
	localparam logic [4:0] OFS_CTRL1 = 5'h07;
	localparam logic [4:0] OFS_BUF0 = 5'h08;
	localparam logic [4:0] OFS_BUF1 = 5'h09;
	localparam logic [4:0] OFS_TRI = 5'h0A;
	localparam logic [4:0] OFS_COS_EN = 5'h0B;

	// Control byte fields
	localparam int CTL_CLO = 0;
	localparam int CTL_B = 1;
	localparam int CTL_CHI = 3;
	localparam int CTL_A = 4;
	localparam int CTL_SET = 7;
	localparam int GROUPS = 2;
	localparam int PORTS = 3;          // A, B, C per group

	// Reset values
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] DIR_IN = 4'hF;  // All ports inputs after reset

	// Host bus request as sampled by the board
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic iow;
		logic ior;
		logic dma;
	} host_req_type;

	// Per-group buffer control towards the line drivers
	typedef struct packed {
		logic [3:0] dir_in;     // A, B, C hi, C lo: 1 = input
		logic enable;           // Drivers out of tristate
	} buf_ctl_type;

endpackage

/* tb_io_window_address_decode.sv */
// Self-checking bench for the host window decoder.
// Assumes the host model drives the bus; straps and irq come from here.
`timescale 1ns/10ps

module tb_io_window_address_decode
	import io_window_pkg::*;
;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] base_strap_fit = 5'h00; // Base 3E0h until changed
	logic [15:0] irq_strap_fit = 16'h0000;
	logic board_irq = 1'b0;
	logic board_sel, sel;
	logic [4:0] board_offset, ofs, b, o;
	logic [15:0] host_irq;
	logic [3:0] grp0_dir_in, grp1_dir_in;
	logic [1:0] buf_enable;
	logic [5:0] cos_enable;
	logic [7:0] c;
	logic [3:0] d;
	host_req_type req;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;

	// Free running 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	host_bus_model i_host (.clk_sys(clk_sys), .board_sel(board_sel),
		.board_offset(board_offset), .req(req));

	io_window_address_decode i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.host_addr(req.addr), .host_wdata(req.wdata),
		.host_iow_n(req.iow), .host_ior_n(req.ior), .host_dma(req.dma),
		.base_strap_fit(base_strap_fit), .irq_strap_fit(irq_strap_fit),
		.board_irq(board_irq), .board_sel(board_sel),
		.board_offset(board_offset), .host_irq(host_irq),
		.grp0_dir_in(grp0_dir_in), .grp1_dir_in(grp1_dir_in),
		.buf_enable(buf_enable), .cos_enable(cos_enable));

	// Lowest fitted level that the board may legally drive
	function automatic logic [15:0] exp_irq(input logic [15:0] fit);
		for (int i = 0; i < 16; i++)
			if (fit[i] && IRQ_LEGAL[i])
				return 16'h0001 << i;
		return 16'h0000;
	endfunction

	// Direction nibble {A, B, C hi, C lo} from a control byte, 1 = input
	function automatic logic [15:0] exp_dir(input logic [7:0] cb);
		return {12'h000, cb[CTL_A], cb[CTL_B], cb[CTL_CHI], cb[CTL_CLO]};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Write helper: base b, offset o, byte v
	task automatic wr(input logic [4:0] o, input logic [7:0] v);
		i_host.bus_cycle({6'h00, b, o}, v, 1'b1, 1'b0, sel, ofs);
	endtask

	// Hang guard, well above the fewer than 1000 cycles the tests need
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end

	initial
	begin
		void'($urandom(32'ha6c1c560));
		repeat (6) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		// Reset state: all inputs, buffers enabled, no change-of-state enables
		check({12'h000, grp0_dir_in}, 16'h000F);
		check({12'h000, grp1_dir_in}, 16'h000F);
		check({14'h0000, buf_enable}, 16'h0003);
		check({10'h000, cos_enable}, 16'h0000);
		$display("test reset done");
		// Random legal bases 100h..3E0h with corners at both ends
		for (int k = 0; k < 12; k++)
		begin
			b = (k == 0) ? 5'h08 : (k == 1) ? 5'h1F : 5'($urandom_range(8, 31));
			o = (k < 2) ? 5'(k * 31) : 5'($urandom_range(0, 31));
			base_strap_fit = ~b;
			repeat (4) @(posedge clk_sys);
			i_host.bus_cycle({6'h00, b, o}, 8'h00, 1'b0, 1'b0, sel, ofs);
			check({15'h0000, sel}, 16'h0001);
			check({11'h000, ofs}, {11'h000, o});
			i_host.bus_cycle({6'h00, b ^ 5'h01, o}, 8'h00, 1'b0, 1'b0, sel, ofs);
			check({15'h0000, sel}, 16'h0000);
			i_host.bus_cycle({6'h04, b, o}, 8'h00, 1'b0, 1'b0, sel, ofs);
			check({15'h0000, sel}, 16'h0000);
			i_host.bus_cycle({6'h00, b, o}, 8'h00, 1'b1, 1'b1, sel, ofs);
			check({15'h0000, sel}, 16'h0000);
		end
		// Base below 100h is never claimed
		b = 5'h07;
		base_strap_fit = ~b;
		repeat (4) @(posedge clk_sys);
		i_host.bus_cycle({6'h00, b, 5'h00}, 8'h00, 1'b0, 1'b0, sel, ofs);
		check({15'h0000, sel}, 16'h0000);
		$display("test decode done");
		b = 5'h18; // Base 300h
		base_strap_fit = ~b;
		repeat (4) @(posedge clk_sys);
		// Per-port change-of-state enables, one hot then random
		for (int k = 0; k < 8; k++)
		begin
			c = (k < 6) ? 8'h01 << k : 8'($urandom);
			wr(OFS_COS_EN, c);
			check({10'h000, cos_enable}, {10'h000, c[5:0]});
		end
		// Writes off the window or in a DMA cycle leave the enables alone
		i_host.bus_cycle({6'h04, b, OFS_COS_EN}, ~c, 1'b1, 1'b0, sel, ofs);
		check({10'h000, cos_enable}, {10'h000, c[5:0]});
		i_host.bus_cycle({6'h00, b, OFS_COS_EN}, ~c, 1'b1, 1'b1, sel, ofs);
		check({10'h000, cos_enable}, {10'h000, c[5:0]});
		$display("test cos enable done");
		// Direction follows control byte; buffers stay on with option clear
		for (int k = 0; k < 6; k++)
		begin
			c = 8'h80 | (8'($urandom) & 8'h1B);
			wr(k[0] ? OFS_CTRL1 : OFS_CTRL0, c);
			d = k[0] ? grp1_dir_in : grp0_dir_in;
			check({12'h000, d}, exp_dir(c));
			check({14'h0000, buf_enable}, 16'h0003);
		end
		// Tristate option on: control write disables, 08h/09h re-enables
		wr(OFS_TRI, 8'h03);
		wr(OFS_CTRL0, 8'h9B);
		check({14'h0000, buf_enable}, 16'h0002);
		wr(OFS_CTRL1, 8'h80);
		check({14'h0000, buf_enable}, 16'h0000);
		check({12'h000, grp1_dir_in}, 16'h0000);
		wr(OFS_BUF0, 8'h00);
		check({14'h0000, buf_enable}, 16'h0001);
		wr(OFS_BUF1, 8'h00);
		wr(OFS_BUF0, 8'h80);
		check({14'h0000, buf_enable}, 16'h0002);
		// Clearing the option puts both groups back to always enabled
		wr(OFS_TRI, 8'h00);
		check({14'h0000, buf_enable}, 16'h0003);
		// Reset in mid-run returns inputs, enabled buffers, option clear
		wr(OFS_TRI, 8'h01);
		wr(OFS_CTRL0, 8'h80);
		check({14'h0000, buf_enable}, 16'h0002);
		arst_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		check({12'h000, grp0_dir_in}, 16'h000F);
		check({14'h0000, buf_enable}, 16'h0003);
		check({10'h000, cos_enable}, 16'h0000);
		wr(OFS_CTRL0, 8'h80);
		check({12'h000, grp0_dir_in}, exp_dir(8'h80));
		check({14'h0000, buf_enable}, 16'h0003);
		$display("test buffers done");
		// Interrupt routed to one legal strapped level only
		for (int k = 0; k < 10; k++)
		begin
			irq_strap_fit = (k < 4) ? 16'h0001 << (k * 4 + 1) : 16'($urandom);
			board_irq = 1'b1;
			repeat (5) @(posedge clk_sys);
			#1;
			check(host_irq, exp_irq(irq_strap_fit));
			board_irq = 1'b0;
			repeat (5) @(posedge clk_sys);
			#1;
			check(host_irq, 16'h0000);
		end
		$display("test irq done");
		finish_test();
	end
endmodule // tb_io_window_address_decode
